// [design/dwg_defines.svh]
`ifndef DWG_DEFINES_SVH
`define DWG_DEFINES_SVH

// register offsets
`define DWG_OFF_COMMAND 8'h01
`define DWG_OFF_ENABLE 8'h02
`define DWG_OFF_STATUS 8'h03
`define DWG_OFF_TIMEOUT 8'h04
`define DWG_OFF_IRQ_MASK 8'h05

// command codes
`define DWG_CODE_PROG_ON 8'h55
`define DWG_CODE_PROG_OFF 8'hAA
`define DWG_CODE_FIXED_ON 8'h33
`define DWG_CODE_FIXED_OFF 8'hCC

// field positions
`define DWG_BIT_PROG 0
`define DWG_BIT_FIXED 1
`define DWG_PHASE_LSB 2
`define DWG_PHASE_MSB 3

// reset values
`define DWG_RST_TIMEOUT 8'h00
`define DWG_RST_PHASE 2'h0
`define DWG_RST_FLAGS 2'h0
`define DWG_RST_MASK 2'h0
`define DWG_RST_ENABLES 1'h0

// timing
`define DWG_CLK_HZ 64'h0000_0000_05F5_E100
`define DWG_CLK_PERIOD_NS 64'h0000_0000_0000_000A
`define DWG_MINUTE_S 64'h0000_0000_0000_003C
`define DWG_MINUTE_CYC (36'(`DWG_MINUTE_S * `DWG_CLK_HZ))
`define DWG_FIXED_MINUTES 8'h04
`define DWG_REQ_PULSE_NS 64'h0000_0000_0000_03E8
`define DWG_REQ_PULSE_CYC \
  (8'((`DWG_REQ_PULSE_NS + `DWG_CLK_PERIOD_NS - 64'h1) / `DWG_CLK_PERIOD_NS))

`endif

// [design/dwg_pkg.sv]
package dwg_pkg;

  typedef enum logic [0:0] {
    GUARD_IDLE = 1'h0,
    GUARD_RUN = 1'h1
  } dwg_guard_e;

  typedef logic [7:0] dwg_byte_t;

endpackage : dwg_pkg

// [design/dwg_tick_if.sv]
`timescale 1ns/1ps
interface dwg_tick_if;
  logic restart;
  logic tick;
  modport counter(input restart, output tick);
  modport user(output restart, input tick);
endinterface : dwg_tick_if

// [design/dwg_minute_prescaler.sv]
`timescale 1ns/1ps
`include "dwg_defines.svh"
module dwg_minute_prescaler #(
  parameter logic [35:0] TICK_CYCLES = `DWG_MINUTE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // tick link
  dwg_tick_if.counter tk
);

  logic [35:0] count_reg;
  logic tick_reg;

  // restart aligns the first tick one full interval after a guard starts
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 36'h0;
      tick_reg <= 1'b0;
    end else if (tk.restart) begin
      count_reg <= 36'h0;
      tick_reg <= 1'b0;
    end else if (count_reg == TICK_CYCLES - 36'h1) begin
      count_reg <= 36'h0;
      tick_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + 36'h1;
      tick_reg <= 1'b0;
    end
  end

  assign tk.tick = tick_reg;

  chk_tick_single_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    tick_reg |=> !tick_reg)
    else $error("minute tick lasted more than one cycle");

  chk_tick_after_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
    tk.restart |=> !tick_reg && count_reg == 36'h0)
    else $error("prescaler did not restart");

endmodule : dwg_minute_prescaler

// [design/dwg_watchdog.sv]
`timescale 1ns/1ps
`include "dwg_defines.svh"
module dwg_watchdog #(
  parameter logic [35:0] MINUTE_CYCLES = `DWG_MINUTE_CYC
) (
  // clock and resume reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_strobe,
  input wire logic reg_rd_strobe,
  output logic [7:0] reg_rd_data,
  // configuration
  input wire logic guard_write_enable,
  // system reset pins
  input wire logic system_reset_input_n,
  output logic system_reset_request_n,
  // interrupt
  output logic irq
);

  function automatic logic [7:0] guard_dec(input logic [7:0] v);
    guard_dec = v - 8'h01;
  endfunction : guard_dec

  // pin synchroniser, reset to the idle high level so no false rise follows reset
  logic sys_rst_s1_reg;
  logic sys_rst_s2_reg;
  logic sys_rst_s3_reg;
  logic sys_rise;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sys_rst_s1_reg <= 1'b1;
      sys_rst_s2_reg <= 1'b1;
      sys_rst_s3_reg <= 1'b1;
    end else begin
      sys_rst_s1_reg <= system_reset_input_n;
      sys_rst_s2_reg <= sys_rst_s1_reg;
      sys_rst_s3_reg <= sys_rst_s2_reg;
    end
  end

  assign sys_rise = sys_rst_s2_reg && !sys_rst_s3_reg;

  // bus decode
  logic wr_ok;
  logic cmd_wr;
  logic timeout_wr;
  logic fixed_stop;
  logic timeout_load;
  logic status_rd;

  assign wr_ok = reg_wr_strobe && guard_write_enable;
  assign cmd_wr = wr_ok && reg_addr == `DWG_OFF_COMMAND;
  assign timeout_wr = wr_ok && reg_addr == `DWG_OFF_TIMEOUT;
  assign fixed_stop = timeout_wr && reg_wr_data == 8'h00;
  assign timeout_load = timeout_wr && reg_wr_data != 8'h00;
  assign status_rd = reg_rd_strobe && reg_addr == `DWG_OFF_STATUS;

  // registers
  logic fixed_en_reg;
  logic prog_en_reg;
  logic [7:0] timeout_reg;
  logic [1:0] phase_reg;
  logic [1:0] flags_reg;
  logic [1:0] mask_reg;

  // guard engines
  dwg_pkg::dwg_guard_e fixed_state_reg;
  dwg_pkg::dwg_guard_e prog_state_reg;
  logic [7:0] fixed_cnt_reg;
  logic [7:0] prog_cnt_reg;
  logic prog_run;
  logic fixed_expire;
  logic prog_expire;

  dwg_tick_if fixed_tk();
  dwg_tick_if prog_tk();

  dwg_minute_prescaler #(.TICK_CYCLES(MINUTE_CYCLES)) u_fixed_minutes (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tk(fixed_tk.counter)
  );

  dwg_minute_prescaler #(.TICK_CYCLES(MINUTE_CYCLES)) u_prog_minutes (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tk(prog_tk.counter)
  );

  // enables
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fixed_en_reg <= `DWG_RST_ENABLES;
    end else if (cmd_wr && reg_wr_data == `DWG_CODE_FIXED_ON) begin
      fixed_en_reg <= 1'b1;
    end else if (cmd_wr && reg_wr_data == `DWG_CODE_FIXED_OFF) begin
      fixed_en_reg <= 1'b0;
    end
  end

  // low reset input and expiry dominate any command
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_en_reg <= `DWG_RST_ENABLES;
    end else if (!sys_rst_s2_reg) begin
      prog_en_reg <= 1'b0;
    end else if (prog_expire) begin
      prog_en_reg <= 1'b0;
    end else if (cmd_wr && reg_wr_data == `DWG_CODE_PROG_ON) begin
      prog_en_reg <= 1'b1;
    end else if (cmd_wr && reg_wr_data == `DWG_CODE_PROG_OFF) begin
      prog_en_reg <= 1'b0;
    end
  end

  // timeout and phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timeout_reg <= `DWG_RST_TIMEOUT;
    end else if (timeout_wr) begin
      timeout_reg <= reg_wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= `DWG_RST_PHASE;
      mask_reg <= `DWG_RST_MASK;
    end else if (wr_ok && reg_addr == `DWG_OFF_STATUS) begin
      phase_reg <= reg_wr_data[`DWG_PHASE_MSB:`DWG_PHASE_LSB];
    end else if (wr_ok && reg_addr == `DWG_OFF_IRQ_MASK) begin
      mask_reg <= reg_wr_data[1:0];
    end
  end

  // sticky flags, expiry wins over read clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= `DWG_RST_FLAGS;
    end else begin
      flags_reg[`DWG_BIT_FIXED] <= fixed_expire ||
        (flags_reg[`DWG_BIT_FIXED] && !status_rd);
      flags_reg[`DWG_BIT_PROG] <= prog_expire ||
        (flags_reg[`DWG_BIT_PROG] && !status_rd);
    end
  end

  assign irq = |(flags_reg & mask_reg);

  // fixed guard
  assign fixed_tk.restart = fixed_en_reg && sys_rise;
  assign fixed_expire = fixed_state_reg == dwg_pkg::GUARD_RUN && fixed_en_reg && !sys_rise &&
    !fixed_stop && fixed_tk.tick && fixed_cnt_reg == 8'h01;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fixed_state_reg <= dwg_pkg::GUARD_IDLE;
      fixed_cnt_reg <= 8'h00;
    end else if (!fixed_en_reg) begin
      fixed_state_reg <= dwg_pkg::GUARD_IDLE;
    end else if (sys_rise) begin
      fixed_state_reg <= dwg_pkg::GUARD_RUN;
      fixed_cnt_reg <= `DWG_FIXED_MINUTES;
    end else begin
      case (fixed_state_reg)
        dwg_pkg::GUARD_IDLE: begin
          fixed_state_reg <= dwg_pkg::GUARD_IDLE;
        end
        dwg_pkg::GUARD_RUN: begin
          if (fixed_stop) begin
            fixed_state_reg <= dwg_pkg::GUARD_IDLE;
          end else if (fixed_tk.tick) begin
            if (fixed_cnt_reg == 8'h01) begin
              fixed_state_reg <= dwg_pkg::GUARD_IDLE;
            end
            fixed_cnt_reg <= guard_dec(fixed_cnt_reg);
          end
        end
        default: begin
          fixed_state_reg <= dwg_pkg::GUARD_IDLE;
        end
      endcase
    end
  end

  // programmable guard
  assign prog_run = prog_en_reg && timeout_reg != 8'h00;
  assign prog_tk.restart = (prog_state_reg == dwg_pkg::GUARD_IDLE && prog_run) ||
    (prog_state_reg == dwg_pkg::GUARD_RUN && timeout_load);
  assign prog_expire = prog_state_reg == dwg_pkg::GUARD_RUN && prog_run && !timeout_load &&
    prog_tk.tick && prog_cnt_reg == 8'h01;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_state_reg <= dwg_pkg::GUARD_IDLE;
      prog_cnt_reg <= 8'h00;
    end else begin
      case (prog_state_reg)
        dwg_pkg::GUARD_IDLE: begin
          if (prog_run) begin
            prog_state_reg <= dwg_pkg::GUARD_RUN;
            prog_cnt_reg <= timeout_reg;
          end
        end
        dwg_pkg::GUARD_RUN: begin
          if (!prog_run) begin
            prog_state_reg <= dwg_pkg::GUARD_IDLE;
          end else if (timeout_load) begin
            prog_cnt_reg <= reg_wr_data;
          end else if (prog_tk.tick) begin
            if (prog_cnt_reg == 8'h01) begin
              prog_state_reg <= dwg_pkg::GUARD_IDLE;
            end
            prog_cnt_reg <= guard_dec(prog_cnt_reg);
          end
        end
        default: begin
          prog_state_reg <= dwg_pkg::GUARD_IDLE;
        end
      endcase
    end
  end

  // reset request pulse
  logic [7:0] req_cnt_reg;
  logic req_n_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_cnt_reg <= 8'h00;
      req_n_reg <= 1'b1;
    end else begin
      if (fixed_expire || prog_expire) begin
        req_cnt_reg <= `DWG_REQ_PULSE_CYC;
      end else if (req_cnt_reg != 8'h00) begin
        req_cnt_reg <= guard_dec(req_cnt_reg);
      end
      req_n_reg <= !(fixed_expire || prog_expire || req_cnt_reg > 8'h01);
    end
  end

  assign system_reset_request_n = req_n_reg;

  // read port, data valid only the cycle after the strobe
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      `DWG_OFF_ENABLE: rd_mux = {6'h00, fixed_en_reg, prog_en_reg};
      `DWG_OFF_STATUS: rd_mux = {4'h0, phase_reg, flags_reg};
      `DWG_OFF_TIMEOUT: rd_mux = timeout_reg;
      `DWG_OFF_IRQ_MASK: rd_mux = {6'h00, mask_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_strobe) begin
      reg_rd_data <= rd_mux;
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  chk_wr_gate_timeout: assert property (
    reg_wr_strobe && !guard_write_enable |=> $stable(timeout_reg) && $stable(phase_reg))
    else $error("write accepted without write enable");

  chk_fixed_arm_four: assert property (
    fixed_en_reg && sys_rise |=> fixed_state_reg == dwg_pkg::GUARD_RUN &&
      fixed_cnt_reg == 8'h04)
    else $error("fixed guard did not arm with four minutes");

  chk_fixed_zero_stop: assert property (
    fixed_stop && !sys_rise |=> fixed_state_reg == dwg_pkg::GUARD_IDLE)
    else $error("zero timeout write did not stop fixed guard");

  chk_expire_request: assert property (
    fixed_expire || prog_expire |=> !system_reset_request_n [*8])
    else $error("reset request not asserted after expiry");

  chk_request_width: assert property (
    req_cnt_reg > 8'h01 |=> !system_reset_request_n)
    else $error("reset request released early");

  chk_prog_start_load: assert property (
    prog_state_reg == dwg_pkg::GUARD_IDLE && prog_run |=>
      prog_state_reg == dwg_pkg::GUARD_RUN && prog_cnt_reg == $past(timeout_reg))
    else $error("programmable guard did not load timeout");

  chk_prog_decrement: assert property (
    prog_state_reg == dwg_pkg::GUARD_RUN && prog_run && !timeout_load && prog_tk.tick |=>
      prog_cnt_reg == $past(prog_cnt_reg) - 8'h01)
    else $error("programmable count did not decrement on tick");

  chk_sysrst_disable: assert property (
    !sys_rst_s2_reg |=> !prog_en_reg ##1 prog_state_reg == dwg_pkg::GUARD_IDLE)
    else $error("low reset input left programmable guard enabled");

  chk_cmd_fixed_on: assert property (
    cmd_wr && reg_wr_data == 8'h33 |=> fixed_en_reg)
    else $error("fixed enable code ignored");

  chk_cmd_other: assert property (
    cmd_wr && reg_wr_data != 8'h55 && reg_wr_data != 8'hAA && reg_wr_data != 8'h33 &&
      reg_wr_data != 8'hCC && sys_rst_s2_reg && !prog_expire |=>
      $stable(fixed_en_reg) && $stable(prog_en_reg))
    else $error("undefined code changed an enable");

  chk_enable_read: assert property (
    reg_rd_strobe && reg_addr == 8'h02 |=>
      reg_rd_data == {6'h00, $past(fixed_en_reg), $past(prog_en_reg)})
    else $error("enable readback wrong");

  chk_status_clear: assert property (
    status_rd && !fixed_expire && !prog_expire |=>
      flags_reg == 2'h0 && reg_rd_data[1:0] == $past(flags_reg))
    else $error("status flags not cleared by read");

  chk_phase_field: assert property (
    wr_ok && reg_addr == 8'h03 |=> phase_reg == $past(reg_wr_data[3:2]))
    else $error("phase field not written");

  chk_reset_defaults: assert property (
    $rose(rstn) |-> timeout_reg == 8'h00 && flags_reg == 2'h0 && !fixed_en_reg)
    else $error("registers not at defaults after reset");

  cov_fixed_expiry: cover property (fixed_en_reg && sys_rise ##[1:1000] fixed_expire);
  cov_prog_expiry: cover property (prog_expire ##1 !system_reset_request_n);
  cov_status_read: cover property (flags_reg != 2'h0 && status_rd);
  cov_fixed_stopped: cover property (fixed_state_reg == dwg_pkg::GUARD_RUN && fixed_stop);

endmodule : dwg_watchdog

// [verification/dwg_sysreset_model.sv]
`timescale 1ns/1ps
module dwg_sysreset_model #(
  parameter int RELEASE_CYCLES = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bench stimulus
  input wire logic force_low,
  // reset pins
  input wire logic system_reset_request_n,
  output logic system_reset_input_n
);
  int hold_cnt;

  // reset circuitry stretches each request into a system reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_cnt <= 0;
    end else if (!system_reset_request_n) begin
      hold_cnt <= RELEASE_CYCLES;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end

  // pin low while forced, requested or stretched
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      system_reset_input_n <= 1'b1;
    end else begin
      system_reset_input_n <= !(force_low || !system_reset_request_n || hold_cnt != 0);
    end
  end
endmodule : dwg_sysreset_model

// [verification/test_dual_watchdog_timer.sv]
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("mismatch %s exp %h got %h", name, exp, got); \
    end \
  end
module test_dual_watchdog_timer;
  localparam int MC = 20;
  logic clk_sys, rstn, reg_wr_strobe, reg_rd_strobe, guard_write_enable;
  logic system_reset_input_n, system_reset_request_n, irq, force_low, rd_d;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, exp_rd, ph, junk;
  logic [1:0] phase;
  logic [7:0] exp_q[$];
  logic [7:0] codes[5];
  logic [7:0] ens[5];
  integer seed;
  int errors, tests_run, cycles, n;

  dwg_watchdog #(.MINUTE_CYCLES(36'(MC))) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_strobe(reg_wr_strobe), .reg_rd_strobe(reg_rd_strobe), .reg_rd_data(reg_rd_data),
    .guard_write_enable(guard_write_enable), .system_reset_input_n(system_reset_input_n),
    .system_reset_request_n(system_reset_request_n), .irq(irq));

  dwg_sysreset_model i_model (
    .clk_sys(clk_sys), .rstn(rstn), .force_low(force_low),
    .system_reset_request_n(system_reset_request_n),
    .system_reset_input_n(system_reset_input_n));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) rd_d <= reg_rd_strobe;
  always @(negedge clk_sys) begin
    if (rd_d) begin
      exp_rd = exp_q.pop_front();
      `CHK("reg_rd_data", exp_rd, reg_rd_data)
    end else if (rstn) begin
      `CHK("rd_idle", 8'h00, reg_rd_data)
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_strobe <= 1'b1;
    @(posedge clk_sys);
    reg_wr_strobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_strobe <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd_strobe <= 1'b0;
  endtask : rd

  task automatic req_check(input int lo, input int hi);
    int k;
    k = 0;
    // sampled mid-cycle, away from the edge that launches the request
    while (system_reset_request_n === 1'b1 && k <= hi) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK("req_delay", 1'b1, k >= lo && k <= hi)
    k = 0;
    while (system_reset_request_n === 1'b0 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK("req_width", 100, k)
  endtask : req_check

  task automatic no_req(input int len);
    logic bad;
    bad = 1'b0;
    repeat (len) begin
      @(negedge clk_sys);
      if (system_reset_request_n !== 1'b1) bad = 1'b1;
    end
    `CHK("no_req", 1'b0, bad)
  endtask : no_req

  task automatic pin_pulse;
    force_low <= 1'b1;
    repeat (4) @(posedge clk_sys);
    force_low <= 1'b0;
  endtask : pin_pulse

  initial begin
    seed = 32'h40DB;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr_strobe = 1'b0;
    reg_rd_strobe = 1'b0;
    guard_write_enable = 1'b1;
    force_low = 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h07, 8'h00);
    guard_write_enable <= 1'b0;
    wr(8'h01, 8'h33);
    wr(8'h04, 8'h05);
    guard_write_enable <= 1'b1;
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h00);
    // every command code plus one stray byte
    do junk = 8'($random(seed)); while (junk inside {8'h55, 8'hAA, 8'h33, 8'hCC});
    codes = '{8'h55, 8'h33, junk, 8'hAA, 8'hCC};
    ens = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(8'h01, codes[i]);
      rd(8'h02, ens[i]);
    end
    ph = 8'($random(seed));
    wr(8'h03, ph);
    phase = ph[3:2];
    rd(8'h03, {4'h0, phase, 2'h0});
    // programmable guard with irq unmasked
    n = 1 + ({$random(seed)} % 3);
    wr(8'h05, 8'h01);
    wr(8'h04, 8'(n));
    wr(8'h01, 8'h55);
    req_check(n * MC, n * MC + 4);
    `CHK("irq", 1'b1, irq)
    rd(8'h03, {4'h0, phase, 2'h1});
    repeat (2) @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    rd(8'h03, {4'h0, phase, 2'h0});
    rd(8'h02, 8'h00);
    repeat (20) @(posedge clk_sys);
    // zero timeout stops a running programmable guard
    wr(8'h04, 8'h02);
    wr(8'h01, 8'h55);
    repeat (MC) @(posedge clk_sys);
    wr(8'h04, 8'h00);
    no_req(2 * MC + 20);
    // low pin stops a running programmable guard
    wr(8'h04, 8'h03);
    wr(8'h01, 8'h55);
    rd(8'h02, 8'h01);
    pin_pulse();
    rd(8'h02, 8'h00);
    no_req(3 * MC + 20);
    // fixed guard armed by the pin rising, irq masked
    wr(8'h01, 8'h33);
    pin_pulse();
    req_check(4 * MC, 4 * MC + 8);
    `CHK("irq", 1'b0, irq)
    rd(8'h03, {4'h0, phase, 2'h2});
    repeat (30) @(posedge clk_sys);
    wr(8'h04, 8'h00);
    no_req(4 * MC + 20);
    rd(8'h02, 8'h02);
    // resume reset with timeout and mask loaded, both guards idle
    wr(8'h04, 8'h09);
    wr(8'h05, 8'h03);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(8'h04, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'h00);
    repeat (4) @(posedge clk_sys);
    finish_test();
  end
endmodule : test_dual_watchdog_timer
